/* core/nv_sram_host.v */
// Host controller driving an 8K x 8 nonvolatile SRAM over its asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "nv_sram_regs.vh"

// Summary of operation
// - Write strobe stays high during read cycles
// - Address changes only while select is high
// - Sequence steps are select falls; enable irrelevant
// - Save/reload issues six ordered reads
// - Write strobe high through all six
module nv_sram_host #(
  parameter POWERUP_CYC = `CYC_POWERUP,
  parameter SAVE_CYC    = `CYC_SAVE,
  parameter RELOAD_CYC  = `CYC_RELOAD,
  parameter [12:0] SEQ_A0 = 13'h0000,
  parameter [12:0] SEQ_A1 = 13'h0001,
  parameter [12:0] SEQ_A2 = 13'h0002,
  parameter [12:0] SEQ_A3 = 13'h0003,
  parameter [12:0] SEQ_A4 = 13'h0004,
  parameter [12:0] SEQ_SAVE_A5   = 13'h0005,
  parameter [12:0] SEQ_RELOAD_A5 = 13'h0006
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // User request and answer
  input  wire        req_valid,
  input  wire [1:0]  req_cmd,
  input  wire [12:0] req_addr,
  input  wire [7:0]  req_wdata,
  output reg         req_ready,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_rdata,
  // Memory pins
  output reg  [12:0] mem_addr,
  output reg         mem_sel_n,
  output reg         mem_wr_n,
  output reg         mem_oe_n,
  output reg  [7:0]  dq_out,
  output reg         dq_oe,
  input  wire [7:0]  dq_in
);
  // Access phases: setup, select low for the strobe, hold, gap
  localparam S_POWER = 3'd0;
  localparam S_IDLE  = 3'd1;
  localparam S_SETUP = 3'd2;
  localparam S_PULSE = 3'd3;
  localparam S_HOLD  = 3'd4;
  localparam S_GAP   = 3'd5;
  localparam S_WAIT  = 3'd6;
  localparam TW = 24;

  // Phase lengths in clock cycles, sized to the phase counter
  localparam [7:0] STROBE_CYC = `CYC_STROBE;
  localparam [7:0] AHOLD_CYC  = `CYC_AHOLD;
  localparam [7:0] SETUP_CYC  = `CYC_SETUP;

  reg [2:0]  state_r;
  reg [1:0]  cmd_r;
  reg [2:0]  step_r;
  reg [7:0]  cyc_r;
  reg        tload_r;
  reg [TW-1:0] tcount_r;
  wire       busy;

  // Request decode
  wire       req_is_seq   = req_cmd[1];
  wire       req_is_save  = (req_cmd == `CMD_SAVE);
  wire       req_is_write = (req_cmd == `CMD_WRITE);

  function [12:0] seq_addr;
    input [2:0] step;
    input       is_save;
    begin
      case (step)
        3'd0:    seq_addr = SEQ_A0;
        3'd1:    seq_addr = SEQ_A1;
        3'd2:    seq_addr = SEQ_A2;
        3'd3:    seq_addr = SEQ_A3;
        3'd4:    seq_addr = SEQ_A4;
        default: seq_addr = is_save ? SEQ_SAVE_A5 : SEQ_RELOAD_A5;
      endcase
    end
  endfunction

  // True on the last cycle of a phase that lasts lim cycles
  function cnt_last;
    input [7:0] cnt;
    input [7:0] lim;
    begin
      cnt_last = (cnt + 8'h01 >= lim);
    end
  endfunction

  // One timer paces the power-up wait and both hold-offs
  nv_wait_timer #(.W(TW)) u_timer (
    .clk   (clk),
    .rst   (rst),
    .load  (tload_r),
    .count (tcount_r),
    .busy  (busy)
  );

  wire is_seq     = cmd_r[1];
  // The timer needs one cycle after a load before busy is valid
  wire timer_done = !tload_r && !busy;

  always @(posedge clk) begin
    if (rst) begin
      state_r   <= S_POWER;
      cmd_r     <= `CMD_READ;
      step_r    <= 3'd0;
      cyc_r     <= 8'h00;
      tload_r   <= 1'b1;
      tcount_r  <= POWERUP_CYC[TW-1:0];
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      // Pins parked: select, strobe and enable high, bus released
      mem_addr  <= 13'h0000;
      mem_sel_n <= 1'b1;
      mem_wr_n  <= 1'b1;
      mem_oe_n  <= 1'b1;
      dq_out    <= 8'h00;
      dq_oe     <= 1'b0;
    end else begin
      tload_r   <= 1'b0;
      rsp_valid <= 1'b0;
      case (state_r)
        S_POWER: begin
          // The device reloads its array after power-up; keep off the bus
          if (timer_done) begin
            state_r   <= S_IDLE;
            req_ready <= 1'b1;
          end
        end
        S_IDLE: begin
          if (req_valid) begin
            req_ready <= 1'b0;
            cmd_r     <= req_cmd;
            step_r    <= 3'd0;
            // Address set while select is high
            mem_addr  <= req_is_seq ? seq_addr(3'd0, req_is_save) : req_addr;
            dq_out    <= req_wdata;
            dq_oe     <= req_is_write;
            mem_wr_n  <= 1'b1;
            cyc_r     <= 8'h00;
            state_r   <= S_SETUP;
          end
        end
        S_SETUP: begin
          // Select falls with the write strobe still high
          mem_sel_n <= 1'b0;
          mem_oe_n  <= (cmd_r != `CMD_READ);
          cyc_r     <= 8'h00;
          state_r   <= S_PULSE;
        end
        S_PULSE: begin
          cyc_r <= cyc_r + 8'h01;
          // Strobe falls a cycle after select, so each cycle starts as a read
          if (cmd_r == `CMD_WRITE && cyc_r == 8'h00) begin
            mem_wr_n <= 1'b0;
          end
          if (cnt_last(cyc_r, STROBE_CYC)) begin
            mem_sel_n <= 1'b1;
            mem_wr_n  <= 1'b1;
            mem_oe_n  <= 1'b1;
            if (cmd_r == `CMD_READ) begin
              rsp_rdata <= dq_in;
              rsp_valid <= 1'b1;
            end
            cyc_r   <= 8'h00;
            state_r <= S_HOLD;
          end
        end
        S_HOLD: begin
          // Address and data held after select rises
          cyc_r <= cyc_r + 8'h01;
          if (cnt_last(cyc_r, AHOLD_CYC)) begin
            dq_oe   <= 1'b0;
            cyc_r   <= 8'h00;
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          cyc_r <= cyc_r + 8'h01;
          if (cnt_last(cyc_r, SETUP_CYC)) begin
            cyc_r <= 8'h00;
            // Next sequence address is set while select is high
            if (is_seq && step_r != 3'd5) begin
              step_r   <= step_r + 3'd1;
              mem_addr <= seq_addr(step_r + 3'd1, cmd_r == `CMD_SAVE);
              state_r  <= S_SETUP;
            end else if (is_seq) begin
              tload_r  <= 1'b1;
              tcount_r <= (cmd_r == `CMD_SAVE) ? SAVE_CYC[TW-1:0]
                                               : RELOAD_CYC[TW-1:0];
              state_r  <= S_WAIT;
            end else begin
              state_r   <= S_IDLE;
              req_ready <= 1'b1;
            end
          end
        end
        S_WAIT: begin
          // Save or reload runs inside the device; no access until it ends
          if (timer_done) begin
            state_r   <= S_IDLE;
            req_ready <= 1'b1;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/nv_sram_regs.vh */
// Timing constants and command codes for the nonvolatile SRAM host controller
`ifndef NV_SRAM_REGS_VH
`define NV_SRAM_REGS_VH

// Clock period in ns
`define CLK_PERIOD_NS       10
// Least strobe and cycle times in ns (slowest speed grade)
`define T_CYCLE_NS          55
`define T_STROBE_NS         45
`define T_ADDR_HOLD_NS      20
`define T_SETUP_NS          10
// Worst-case nonvolatile durations
`define T_POWERUP_US        550
`define T_SAVE_MS           10
`define T_RELOAD_US         20
// Cycle counts derived from the times above; least times round up
`define CYC_CYCLE    ((`T_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_STROBE   ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_AHOLD    ((`T_ADDR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SETUP    ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_POWERUP  ((`T_POWERUP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_SAVE     ((`T_SAVE_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_RELOAD   ((`T_RELOAD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Command codes
`define CMD_READ     2'h0
`define CMD_WRITE    2'h1
`define CMD_SAVE     2'h2
`define CMD_RELOAD   2'h3

`endif

/* core/nv_wait_timer.v */
// Down counter that holds the host off the memory for a loaded number of cycles
`timescale 1ns/1ps
`default_nettype none
module nv_wait_timer #(
  parameter W = 24
) (
  // Clock and reset
  input  wire         clk,
  input  wire         rst,
  // Load and status
  input  wire         load,
  input  wire [W-1:0] count,
  output wire         busy
);
  reg [W-1:0] cnt_r;

  always @(posedge clk) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
    end else if (load) begin
      cnt_r <= count;
    end else if (cnt_r != {W{1'b0}}) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
    end
  end

  assign busy = (cnt_r != {W{1'b0}});
endmodule
`default_nettype wire

/* sim/nv_sram_model.sv */
// Behavioural model of the nonvolatile SRAM device
`timescale 1ns/1ps
`default_nettype none
module nv_sram_model #(parameter [12:0] SA5 = 13'h0005, RA5 = 13'h0006) (
  // Memory pins
  input  wire logic [12:0] addr,
  input  wire logic        sel_n, wr_n, oe_n,
  input  wire logic [7:0]  din,
  output var  logic [7:0]  dout,
  // Sequence status
  output var  int          saves, reloads
);
  logic [7:0] mem [8192];
  logic [7:0] last = 8'h00;
  int         step = 0;
  initial saves = 0;
  initial reloads = 0;
  always @* if (!sel_n && !wr_n) mem[addr] = din;
  // Released bus shows the inverse of the last driven byte
  always @* begin
    if (!sel_n && !oe_n && wr_n) begin
      dout = mem[addr];
      last = mem[addr];
    end else dout = ~last;
  end
  always @(negedge sel_n) begin
    if (wr_n && step < 5 && addr == 13'(step)) step++;
    else if (wr_n && step == 5 && addr == SA5) begin saves++; step = 0; end
    else if (wr_n && step == 5 && addr == RA5) begin reloads++; step = 0; end
    else step = 0;
  end
endmodule
`default_nettype wire

/* sim/nv_sram_host_chk.sv */
// Assertions on the host controller's pins and handshake
`timescale 1ns/1ps
`default_nettype none
module nv_sram_host_chk (
  input wire logic        clk, rst, req_valid, req_ready, rsp_valid,
  input wire logic [1:0]  req_cmd,
  input wire logic [12:0] mem_addr,
  input wire logic        mem_sel_n, mem_wr_n, mem_oe_n, dq_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire take = req_valid && req_ready;
  a_read_wr_high: assert property (!mem_oe_n |-> mem_wr_n) else $error("wr in read");
  a_wr_after_sel: assert property ($fell(mem_wr_n) |-> !$past(mem_sel_n)) else $error("wr");
  a_no_contend: assert property (dq_oe |-> mem_oe_n) else $error("contention");
  a_addr_steady: assert property (!mem_sel_n && !$past(mem_sel_n) |-> $stable(mem_addr))
    else $error("addr moved");
  a_seq_no_strobe: assert property (take && req_cmd[1] |=> (mem_oe_n && mem_wr_n) [*8])
    else $error("seq strobe");
  a_read_answer: assert property (take && req_cmd == 2'h0 |-> ##[6:7] rsp_valid)
    else $error("no answer");
  a_one_take: assert property (take |=> !req_ready) else $error("ready stuck");
  a_powerup_wait: assert property ($fell(rst) |-> !req_ready [*8]) else $error("early");
endmodule
bind nv_sram_host nv_sram_host_chk chk_u (.clk, .rst, .req_valid, .req_ready, .rsp_valid,
  .req_cmd, .mem_addr, .mem_sel_n, .mem_wr_n, .mem_oe_n, .dq_oe);
`default_nettype wire

/* sim/tb_nv_sram_host.sv */
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/1ps
`default_nettype none
module tb_nv_sram_host;
  logic        clk = 0, rst = 1, req_valid = 0;
  logic [1:0]  req_cmd = 0;
  logic [12:0] req_addr = 0, mem_addr, a;
  logic [7:0]  req_wdata = 0, rsp_rdata, dq_out, dq_in, d;
  logic        req_ready, rsp_valid, mem_sel_n, mem_wr_n, mem_oe_n, dq_oe;
  int          n_fail = 0, checks_done = 0, saves, reloads, n;
  logic [7:0]  ref_m [int];
  time         t_nv = 0, t_fall = 0;
  localparam int POWER_T = 20, SAVE_T = 40, RELOAD_T = 10;
  initial forever #5 clk = ~clk;
  // Last sequence completion and last select fall, for the hold-off checks
  always @(saves, reloads) t_nv = $time;
  always @(negedge mem_sel_n) t_fall = $time;
  nv_sram_host #(.POWERUP_CYC(POWER_T), .SAVE_CYC(SAVE_T), .RELOAD_CYC(RELOAD_T)) dut_u (
    .clk, .rst,
    .req_valid, .req_cmd, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata,
    .mem_addr, .mem_sel_n, .mem_wr_n, .mem_oe_n, .dq_out, .dq_oe, .dq_in);
  nv_sram_model mdl_u (.addr(mem_addr), .sel_n(mem_sel_n), .wr_n(mem_wr_n),
    .oe_n(mem_oe_n), .din(dq_oe ? dq_out : 8'hzz), .dout(dq_in), .saves, .reloads);
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until the edge that takes it; n counts the wait
  task go(input logic [1:0] c, input logic [12:0] ad, input logic [7:0] dd);
    req_valid <= 1;
    req_cmd <= c;
    req_addr <= ad;
    req_wdata <= dd;
    n = 0;
    do begin @(posedge clk); n++; end while (req_ready !== 1'b1 && n < 5000);
    req_valid <= 0;
    if (n >= 5000) begin n_fail++; end_sim; end
    @(posedge clk);
  endtask
  task rd(input logic [12:0] ad);
    int k;
    go(2'h0, ad, 8'h00);
    k = n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin @(posedge clk); n++; end
    chk(n < 20, 1);
    chk(rsp_rdata, ref_m[ad]);
    n = k;
  endtask
  initial begin
    void'($urandom(14687));
    repeat (16) @(posedge clk);
    rst <= 0;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin @(posedge clk); n++; end
    chk(n > POWER_T && n < 500, 1);
    $display("power-up test done");
    for (int i = 0; i < 8; i++) begin
      a = 13'($urandom) | 13'h0100;
      d = 8'($urandom);
      ref_m[a] = d;
      go(2'h1, a, d);
      rd(a);
    end
    $display("write and read test done");
    go(2'h2, 13'h0000, 8'h00);
    rd(a);
    chk(n > 90, 1);
    chk((t_fall - t_nv) / 10 >= SAVE_T, 1);
    chk(saves, 1);
    $display("save test done");
    go(2'h3, 13'h0000, 8'h00);
    rd(a);
    chk(n > 60, 1);
    chk((t_fall - t_nv) / 10 >= RELOAD_T, 1);
    chk(reloads, 1);
    $display("reload test done");
    end_sim;
  end
endmodule
`default_nettype wire
